// [logic/dmx_pkg.sv]
// Constants and types for the data-move instruction engine.
// Operation
// - Word prefix 0101 00 moves a file byte to the chosen destination, updating N, Z.
// - Destination bit 0 writes the working register, 1 writes back the file byte.
// - File-to-file move is two words: 1100 plus source, 1111 plus destination.
// - File-to-file move addresses 000h to FFFh directly, no bank, flags unchanged.
// - The working register may be source or destination of the file-to-file move.
// - File-to-file move takes two cycles: source read first, destination written second.
// - Literal-to-bank-select loads the 8-bit literal into the bank register, flags unchanged.
// - Pattern 0000 0001 plus literal is literal-to-bank-select, one cycle.
// - Literal-to-working loads the literal into the working register, flags unchanged.
// - Pattern 0000 1110 plus literal is literal-to-working, one cycle.
// - Working-to-file writes the working register to the file, nothing else changes.
// - Prefix 0110 111, access bit, 8-bit file is working-to-file, one cycle.
// - An 8-bit file field addresses a byte within one 256-byte bank.
// - Access bit 0 selects the access bank and ignores the bank register.
// - Access bit 1 takes the bank number from the bank register.
package dmx_pkg;
  localparam logic [7:0]  ADR_INSTR      = 8'h00;
  localparam logic [7:0]  ADR_WORKING    = 8'h04;
  localparam logic [7:0]  ADR_BANK       = 8'h08;
  localparam logic [7:0]  ADR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADR_MEM_ADDR   = 8'h10;
  localparam logic [7:0]  ADR_MEM_DATA   = 8'h14;
  localparam logic [5:0]  OPC_MOVE_FILE  = 6'h14;
  localparam logic [3:0]  OPC_FF_SRC     = 4'hC;
  localparam logic [3:0]  OPC_FF_DST     = 4'hF;
  localparam logic [7:0]  OPC_LIT_BANK   = 8'h01;
  localparam logic [7:0]  OPC_LIT_WORK   = 8'h0E;
  localparam logic [6:0]  OPC_WORK_FILE  = 7'h37;
  localparam logic [11:0] WORKING_ADDR   = 12'hFE8;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0]  RST_WORKING    = 8'h00;
  localparam logic [7:0]  RST_BANK       = 8'h00;
  localparam logic [11:0] RST_MEM_ADDR   = 12'h000;
  localparam int          STS_Z_BIT      = 0;
  localparam int          STS_N_BIT      = 1;
  localparam int          STS_PEND_BIT   = 2;
  localparam int          STS_NOP_BIT    = 3;

  typedef struct packed {
    logic n;
    logic z;
  } dmx_flags_s;

  typedef enum logic [2:0] {
    OP_NONE, OP_MOVE_FILE, OP_FF_FIRST, OP_FF_SECOND,
    OP_LIT_BANK, OP_LIT_WORK, OP_WORK_FILE
  } dmx_op_e;

  typedef enum logic [0:0] {ST_READY, ST_SECOND} dmx_st_e;

  typedef struct packed {
    dmx_op_e     op;
    logic        dest;
    logic        acc;
    logic [7:0]  fil;
    logic [11:0] far;
  } dmx_dec_s;
endpackage : dmx_pkg

// [logic/dmx_core.sv]
// Data-move instruction engine with a classic Wishbone register slave.
`timescale 1ns/1ps
module dmx_core (
  input  wire logic        clk_i,     // Core clock, 100 MHz.
  input  wire logic        rst_i,     // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,  // Bus cycle.
  input  wire logic        wb_stb_i,  // Bus strobe.
  input  wire logic        wb_we_i,   // Write enable.
  input  wire logic [7:0]  wb_adr_i,  // Byte address.
  input  wire logic [3:0]  wb_sel_i,  // Byte lane selects.
  input  wire logic [31:0] wb_dat_i,  // Write data.
  output logic      [31:0] wb_dat_o,  // Read data.
  output logic             wb_ack_o,  // Acknowledge.
  output logic      [7:0]  working_o, // Working register.
  output logic      [7:0]  bank_o,    // Bank select register.
  output logic      [1:0]  flags_o,   // Negative and zero flags.
  output logic             pending_o  // Second word expected.
);

  // ********************************************************
  // State
  // ********************************************************
  // Data memory holds no reset; every register, the working register included, is cleared.
  logic [7:0]  mem [0:4095];
  logic [7:0]  working_reg, working_next;
  logic [7:0]  bank_reg, bank_next;
  logic [7:0]  src_reg, src_next;
  logic [11:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        nop_reg, nop_next;
  dmx_pkg::dmx_flags_s flags_reg, flags_next;
  dmx_pkg::dmx_st_e    st_reg, st_next;
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        acc_w, wr_w, instr_wr;
  dmx_pkg::dmx_dec_s dec_w;
  logic [11:0] fa_w;
  logic [7:0]  rdv_w, rdf_w;

  // ********************************************************
  // Functions
  // ********************************************************
  function automatic dmx_pkg::dmx_dec_s decode(input logic [15:0] w);
    dmx_pkg::dmx_dec_s d;
    d = '{op: dmx_pkg::OP_NONE, dest: w[9], acc: w[8], fil: w[7:0], far: w[11:0]};
    if (w[15:10] == dmx_pkg::OPC_MOVE_FILE) begin
      d.op = dmx_pkg::OP_MOVE_FILE;
    end else if (w[15:12] == dmx_pkg::OPC_FF_SRC) begin
      d.op = dmx_pkg::OP_FF_FIRST;
    end else if (w[15:12] == dmx_pkg::OPC_FF_DST) begin
      d.op = dmx_pkg::OP_FF_SECOND;
    end else if (w[15:8] == dmx_pkg::OPC_LIT_BANK) begin
      d.op = dmx_pkg::OP_LIT_BANK;
    end else if (w[15:8] == dmx_pkg::OPC_LIT_WORK) begin
      d.op = dmx_pkg::OP_LIT_WORK;
    end else if (w[15:9] == dmx_pkg::OPC_WORK_FILE) begin
      d.op = dmx_pkg::OP_WORK_FILE;
    end
    return d;
  endfunction : decode

  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                            input logic [7:0] b);
    logic [11:0] r;
    if (a) begin
      r = {b[3:0], f};
    end else if (f < dmx_pkg::ACCESS_SPLIT) begin
      r = {4'h0, f};
    end else begin
      r = {dmx_pkg::ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : file_addr

  // The working register also answers at its data-space address.
  function automatic logic [7:0] rd(input logic [11:0] a);
    logic [7:0] r;
    r = (a == dmx_pkg::WORKING_ADDR) ? working_reg : mem[a];
    return r;
  endfunction : rd

  // ********************************************************
  // Decode
  // ********************************************************
  assign acc_w    = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_w     = acc_w & wb_we_i;
  assign instr_wr = wr_w & (wb_adr_i == dmx_pkg::ADR_INSTR) & (&wb_sel_i[1:0]);
  assign dec_w    = decode(wb_dat_i[15:0]);
  assign fa_w     = file_addr(dec_w.acc, dec_w.fil, bank_reg);

  // A continuous assignment would not wake up when the memory or the working
  // register changes under a steady address, so the reads live in a process.
  always_comb begin
    rdv_w = rd(fa_w);
    rdf_w = rd(dec_w.far);
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    working_next = working_reg;
    bank_next    = bank_reg;
    flags_next   = flags_reg;
    st_next      = st_reg;
    src_next     = src_reg;
    addr_next    = addr_reg;
    nop_next     = nop_reg;
    mem_we       = 1'b0;
    mem_wa       = addr_reg;
    mem_wd       = wb_dat_i[7:0];
    ack_next     = acc_w;
    rdata_next   = 32'h0000_0000;
    if (instr_wr) begin
      // An abandoned first word is dropped by any other word.
      st_next  = dmx_pkg::ST_READY;
      nop_next = 1'b0;
      case (dec_w.op)
        dmx_pkg::OP_MOVE_FILE: begin
          // N from bit 7, Z on zero.
          flags_next.n = rdv_w[7];
          flags_next.z = (rdv_w == 8'h00);
          if (dec_w.dest) begin
            mem_we = 1'b1;
            mem_wa = fa_w;
            mem_wd = rdv_w;
          end else begin
            working_next = rdv_w;
          end
        end
        dmx_pkg::OP_FF_FIRST: begin
          src_next = rdf_w;
          st_next  = dmx_pkg::ST_SECOND;
        end
        dmx_pkg::OP_FF_SECOND: begin
          if (st_reg == dmx_pkg::ST_SECOND) begin
            mem_we = 1'b1;
            mem_wa = dec_w.far;
            mem_wd = src_reg;
          end else begin
            nop_next = 1'b1;
          end
        end
        dmx_pkg::OP_LIT_BANK: begin
          bank_next = dec_w.fil;
        end
        dmx_pkg::OP_LIT_WORK: begin
          working_next = dec_w.fil;
        end
        dmx_pkg::OP_WORK_FILE: begin
          mem_we = 1'b1;
          mem_wa = fa_w;
          mem_wd = working_reg;
        end
        default: begin
        end
      endcase
    end else if (wr_w & wb_sel_i[0]) begin
      if (wb_adr_i == dmx_pkg::ADR_WORKING) begin
        working_next = wb_dat_i[7:0];
      end else if (wb_adr_i == dmx_pkg::ADR_BANK) begin
        bank_next = wb_dat_i[7:0];
      end else if (wb_adr_i == dmx_pkg::ADR_STATUS) begin
        flags_next.n = wb_dat_i[dmx_pkg::STS_N_BIT];
        flags_next.z = wb_dat_i[dmx_pkg::STS_Z_BIT];
      end else if (wb_adr_i == dmx_pkg::ADR_MEM_ADDR && wb_sel_i[1]) begin
        addr_next = wb_dat_i[11:0];
      end else if (wb_adr_i == dmx_pkg::ADR_MEM_DATA) begin
        mem_we = 1'b1;
      end
    end
    // working register as a data-space location.
    if (mem_we && mem_wa == dmx_pkg::WORKING_ADDR) begin
      working_next = mem_wd;
      mem_we       = 1'b0;
    end
    if (acc_w && !wb_we_i) begin
      if (wb_adr_i == dmx_pkg::ADR_WORKING) begin
        rdata_next[7:0] = working_reg;
      end else if (wb_adr_i == dmx_pkg::ADR_BANK) begin
        rdata_next[7:0] = bank_reg;
      end else if (wb_adr_i == dmx_pkg::ADR_STATUS) begin
        rdata_next[dmx_pkg::STS_N_BIT]    = flags_reg.n;
        rdata_next[dmx_pkg::STS_Z_BIT]    = flags_reg.z;
        rdata_next[dmx_pkg::STS_PEND_BIT] = (st_reg == dmx_pkg::ST_SECOND);
        rdata_next[dmx_pkg::STS_NOP_BIT]  = nop_reg;
      end else if (wb_adr_i == dmx_pkg::ADR_MEM_ADDR) begin
        rdata_next[11:0] = addr_reg;
      end else if (wb_adr_i == dmx_pkg::ADR_MEM_DATA) begin
        rdata_next[7:0] = rd(addr_reg);
      end
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_reg <= dmx_pkg::RST_WORKING;
      bank_reg    <= dmx_pkg::RST_BANK;
      flags_reg   <= '{n: 1'b0, z: 1'b0};
      st_reg      <= dmx_pkg::ST_READY;
      src_reg     <= 8'h00;
      addr_reg    <= dmx_pkg::RST_MEM_ADDR;
      rdata_reg   <= 32'h0000_0000;
      ack_reg     <= 1'b0;
      nop_reg     <= 1'b0;
    end else begin
      working_reg <= working_next;
      bank_reg    <= bank_next;
      flags_reg   <= flags_next;
      st_reg      <= st_next;
      src_reg     <= src_next;
      addr_reg    <= addr_next;
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
      nop_reg     <= nop_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign wb_dat_o  = rdata_reg;
  assign wb_ack_o  = ack_reg;
  assign working_o = working_reg;
  assign bank_o    = bank_reg;
  assign flags_o   = flags_reg;
  assign pending_o = (st_reg == dmx_pkg::ST_SECOND);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_move_flags: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_MOVE_FILE |=>
      flags_reg.n == $past(rdv_w[7]) && flags_reg.z == ($past(rdv_w) == 8'h00))
    else $error("move-file flags wrong");
  a_move_to_work: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_MOVE_FILE && !dec_w.dest |=>
      working_reg == $past(rdv_w))
    else $error("move-file to working register wrong");
  a_move_to_file: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_MOVE_FILE && dec_w.dest &&
    fa_w != dmx_pkg::WORKING_ADDR |=> mem[$past(fa_w)] == $past(rdv_w) &&
      $stable(working_reg))
    else $error("move-file back to file wrong");
  a_ff_source: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_FF_FIRST |=>
      pending_o && src_reg == $past(rdf_w))
    else $error("file-to-file source not latched");
  a_ff_dest: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_FF_SECOND && pending_o &&
    dec_w.far != dmx_pkg::WORKING_ADDR |=> mem[$past(dec_w.far)] == $past(src_reg) && !pending_o)
    else $error("file-to-file destination wrong");
  a_ff_flags: assert property (
    instr_wr && (dec_w.op == dmx_pkg::OP_FF_FIRST || dec_w.op == dmx_pkg::OP_FF_SECOND)
      |=> $stable(flags_reg))
    else $error("file-to-file changed flags");
  a_ff_working: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_FF_SECOND && pending_o &&
    dec_w.far == dmx_pkg::WORKING_ADDR |=> working_reg == $past(src_reg))
    else $error("file-to-file into working register wrong");
  a_lit_bank: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_LIT_BANK |=>
      bank_reg == $past(dec_w.fil) && $stable(flags_reg))
    else $error("bank literal wrong");
  a_lit_work: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_LIT_WORK |=>
      working_reg == $past(dec_w.fil) && $stable(flags_reg))
    else $error("working literal wrong");
  a_work_file: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_WORK_FILE && fa_w != dmx_pkg::WORKING_ADDR |=>
      mem[$past(fa_w)] == $past(working_reg) && $stable(working_reg) && $stable(flags_reg))
    else $error("working-to-file wrong");
  a_bank_select: assert property (
    instr_wr && dec_w.acc |-> fa_w == {bank_reg[3:0], dec_w.fil})
    else $error("banked address wrong");
  a_access_bank: assert property (
    instr_wr && !dec_w.acc |-> fa_w[7:0] == dec_w.fil &&
      (fa_w[11:8] == 4'h0 || fa_w[11:8] == dmx_pkg::ACCESS_HI_BANK))
    else $error("access bank address wrong");
  a_lone_second: assert property (
    instr_wr && dec_w.op == dmx_pkg::OP_FF_SECOND && !pending_o |=>
      nop_reg && $stable(working_reg) && $stable(flags_reg))
    else $error("lone second word not ignored");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  c_ff_pair: cover property (
    instr_wr && dec_w.op == dmx_pkg::OP_FF_FIRST ##[1:20]
    instr_wr && dec_w.op == dmx_pkg::OP_FF_SECOND);
  c_move_zero: cover property (
    instr_wr && dec_w.op == dmx_pkg::OP_MOVE_FILE && rdv_w == 8'h00);
  c_lone_nop: cover property (nop_reg);
endmodule : dmx_core

// [tb/data_move_instruction_exec_tb.sv]
// Self-checking bench for the data-move instruction engine.
`timescale 1ns/1ps
module data_move_instruction_exec_tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  working;
  logic [7:0]  bank;
  logic [1:0]  flags;
  logic        pending;
  logic [31:0] scratch;
  logic [7:0]  ew;
  int          errors;
  int          tests_run;
  logic [7:0]  mv_val [3] = '{8'h5A, 8'h00, 8'h80};
  logic [11:0] mv_adr [3] = '{12'h020, 12'h540, 12'hFA0};
  logic [15:0] mv_ins [3] = '{16'h5020, 16'h5140, 16'h52A0};

  dmx_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .working_o(working), .bank_o(bank), .flags_o(flags),
    .pending_o(pending));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Bus access and comparison tasks
  // ****************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The master waits up to 50 cycles for ack; a silent slave ends the run as a mismatch.
  task automatic wb_acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      errors++;
      $display("Error bus ack expected 1 seen %b", ack);
      stop_test();
    end
    r = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : wb_acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_acc(1'b1, a, d, scratch);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    wb_acc(1'b0, a, 32'h0, scratch);
    chk(what, e, scratch);
  endtask : rd_chk

  task automatic instr(input logic [15:0] w);
    wr(dmx_pkg::ADR_INSTR, {16'h0, w});
  endtask : instr

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
    wr(dmx_pkg::ADR_MEM_ADDR, {20'h0, a});
    wr(dmx_pkg::ADR_MEM_DATA, {24'h0, v});
  endtask : mem_wr

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
    wr(dmx_pkg::ADR_MEM_ADDR, {20'h0, a});
    rd_chk("memory byte", dmx_pkg::ADR_MEM_DATA, {24'h0, v});
  endtask : mem_chk

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("working reset", dmx_pkg::ADR_WORKING, 32'h0);
    rd_chk("bank reset", dmx_pkg::ADR_BANK, 32'h0);
    rd_chk("status reset", dmx_pkg::ADR_STATUS, 32'h0);
    rd_chk("unmapped read", 8'h20, 32'h0);
    $display("Test reset done");
    wr(dmx_pkg::ADR_STATUS, 32'h3);
    instr(16'h0E5A);
    chk("working literal", 32'h5A, {24'h0, working});
    chk("flags after working literal", 32'h3, {30'h0, flags});
    instr(16'h0105);
    chk("bank literal", 32'h05, {24'h0, bank});
    chk("flags after bank literal", 32'h3, {30'h0, flags});
    $display("Test literals done");
    instr(16'h6F33);
    mem_chk(12'h533, 8'h5A);
    instr(16'h6E20);
    mem_chk(12'h020, 8'h5A);
    instr(16'h6E90);
    mem_chk(12'hF90, 8'h5A);
    chk("working after store", 32'h5A, {24'h0, working});
    rd_chk("status after store", dmx_pkg::ADR_STATUS, 32'h3);
    $display("Test working to file done");
    wr(dmx_pkg::ADR_WORKING, 32'h77);
    ew = 8'h77;
    for (int i = 0; i < 3; i++) begin
      mem_wr(mv_adr[i], mv_val[i]);
      instr(mv_ins[i]);
      if (mv_ins[i][9] == 1'b0) ew = mv_val[i];
      chk("working after move", {24'h0, ew}, {24'h0, working});
      chk("move flags", {30'h0, mv_val[i][7], mv_val[i] == 8'h00}, {30'h0, flags});
      mem_chk(mv_adr[i], mv_val[i]);
    end
    $display("Test move file done");
    mem_wr(12'h000, 8'hC3);
    mem_wr(12'hFFF, 8'h11);
    instr(16'hC000);
    chk("pending after first word", 32'h1, {31'h0, pending});
    mem_chk(12'hFFF, 8'h11);
    instr(16'hFFFF);
    mem_chk(12'hFFF, 8'hC3);
    chk("pending after second word", 32'h0, {31'h0, pending});
    chk("flags after file copy", 32'h2, {30'h0, flags});
    instr(16'hCFE8);
    instr(16'hF100);
    mem_chk(12'h100, ew);
    instr(16'hC000);
    instr(16'hFFE8);
    chk("working as copy target", 32'hC3, {24'h0, working});
    $display("Test file to file done");
    mem_wr(12'h123, 8'h44);
    instr(16'hF123);
    mem_chk(12'h123, 8'h44);
    rd_chk("status after lone word", dmx_pkg::ADR_STATUS, 32'hA);
    instr(16'hC000);
    instr(16'h0E11);
    chk("pending after cancel", 32'h0, {31'h0, pending});
    instr(16'hF123);
    mem_chk(12'h123, 8'h44);
    chk("working after cancel", 32'h11, {24'h0, working});
    $display("Test lone second word done");
    stop_test();
  end
endmodule : data_move_instruction_exec_tb
